// ### hbp_dead_band.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Shared constants
// ----------------------------------------------------------------
package hbp_pkg;
    localparam int         CLK_PERIOD_NS  = 4;    // System clock period
    localparam int         TCY_OSC_CYCLES = 4;    // Clocks per instruction cycle
    localparam int         TCY_DIV        = TCY_OSC_CYCLES * 4 / CLK_PERIOD_NS;
    localparam int         DB_WIDTH       = 7;
    localparam int         ADDR_W         = 2;
    localparam int         DATA_W         = 8;
    // Register offsets
    localparam logic [1:0] OFS_CTRL       = 2'h0;
    localparam logic [1:0] OFS_DBAND      = 2'h1;
    localparam logic [1:0] OFS_SHDN       = 2'h2;
    localparam logic [1:0] OFS_AUX        = 2'h3;
    // Field positions
    localparam int         CTRL_HALF_BIT  = 7;
    localparam int         CTRL_EN_BIT    = 3;
    localparam int         CTRL_POLB_BIT  = 1;
    localparam int         CTRL_POLA_BIT  = 0;
    localparam int         DB_ARST_BIT    = 7;
    localparam int         SD_FLAG_BIT    = 7;
    localparam int         SD_SRC_LSB     = 4;
    localparam int         SD_STA_LSB     = 2;
    localparam int         SD_STB_LSB     = 0;
    localparam int         SRC_CMP_BIT    = 0;
    localparam int         SRC_INT_BIT    = 2;
    localparam int         AUX_SYNC_BIT   = 0;
    localparam int         AUX_DIRA_BIT   = 1;
    localparam int         AUX_DIRB_BIT   = 2;
    localparam int         AUX_PTF_BIT    = 7;
    // Reset values
    localparam logic [7:0] CTRL_RST       = 8'h00;
    localparam logic [7:0] DBAND_RST      = 8'h00;
    localparam logic [6:0] SHDN_RST       = 7'h00;
    localparam logic [2:0] AUX_RST        = 3'h6;
    // Shutdown sequencing
    typedef enum logic [1:0] {
        HBP_ST_IDLE   = 2'b00,
        HBP_ST_RUN    = 2'b01,
        HBP_ST_SHUT   = 2'b11,
        HBP_ST_RESUME = 2'b10
    } hbp_state_e;
endpackage

// ----------------------------------------------------------------
// Dead-band delay on the active-going edge of one output
// ----------------------------------------------------------------
module hbp_dead_band #(
    parameter int DB_W = 7
) (
    input  wire logic            i_clk,
    input  wire logic            i_rst_n,
    input  wire logic            i_tcy,
    input  wire logic            i_sched,
    input  wire logic [DB_W-1:0] i_count,
    output logic                 o_active
);
    logic [DB_W-1:0] cnt_q;
    logic            wait_q;
    logic            sched_q;

    // Delay count and wait state
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q    <= '0;
            wait_q   <= 1'b0;
            sched_q  <= 1'b0;
            o_active <= 1'b0;
        end else begin
            sched_q <= i_sched;
            if (!i_sched) begin
                wait_q   <= 1'b0;
                o_active <= 1'b0;
            end else if (!sched_q) begin
                if (i_count == '0) begin
                    o_active <= 1'b1;
                end else begin
                    cnt_q  <= i_count;
                    wait_q <= 1'b1;
                end
            end else if (wait_q && i_tcy) begin
                cnt_q <= cnt_q - 1'b1;
                if (cnt_q == {{(DB_W-1){1'b0}}, 1'b1}) begin
                    wait_q   <= 1'b0;
                    o_active <= 1'b1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    property p_db_zero;
        i_sched && !sched_q && i_count == '0 |=> o_active;
    endproperty
    a_db_zero: assert property (p_db_zero) else $error("zero delay not immediate");

    property p_db_hold;
        wait_q |-> !o_active;
    endproperty
    a_db_hold: assert property (p_db_hold) else $error("active during dead band");

    property p_db_drop;
        !i_sched |=> !o_active && !wait_q;
    endproperty
    a_db_drop: assert property (p_db_drop) else $error("short duty not suppressed");
endmodule // hbp_dead_band

// ### hbp_top.sv
`timescale 1ns/1ns
// Function
// - Output B is complement of A in half-bridge
// - Dead-band count delays active-going edge
// - Delay longer than duty keeps output inactive
// - Two bits choose polarity per output
// - Period flag set when next period begins
// - Pins high impedance after reset
// - Source field selects comparator, pin, both
// - Firmware setting the flag is an event
// - Event sets flag, held until cleared
// - Shutdown forces pins asynchronously
// - A shutdown state: low, high, tri-state
// - B shutdown state: low, high, tri-state
// - Shutdown is level based, persists
// - Flag writes ignored while condition present
// - Resume only at next period start
// - Auto-restart clears flag when condition gone
// - Comparator sync delays comparator shutdown
// - Delay only on inactive-to-active, in Tcy
module hbp_top
    import hbp_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_rstn,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic       [DATA_W-1:0] o_rdata,
    input  wire logic              i_period_match,
    input  wire logic              i_duty_match,
    input  wire logic              i_duty_zero,
    input  wire logic              i_int_pin,
    input  wire logic              i_cmp_out,
    input  wire logic              i_tmr1_tick,
    output logic                   o_pwm_out_a,
    output logic                   o_pwm_out_a_oe_n,
    output logic                   o_pwm_out_b,
    output logic                   o_pwm_out_b_oe_n,
    output logic                   o_period_timer_flag
);
    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic rst_meta_q;
    logic rst_n_q;

    // Two-stage release of the reset
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0]  ctrl_q;
    logic [7:0]  dband_q;
    logic [6:0]  shdn_q;
    logic [2:0]  aux_q;
    logic        flag_q;
    logic        ptf_q;
    logic        cond_s;
    hbp_state_e  st_q;

    logic wr_ctrl;
    logic wr_dband;
    logic wr_shdn;
    logic wr_aux;
    assign wr_ctrl  = i_wr && (i_addr == OFS_CTRL);
    assign wr_dband = i_wr && (i_addr == OFS_DBAND);
    assign wr_shdn  = i_wr && (i_addr == OFS_SHDN);
    assign wr_aux   = i_wr && (i_addr == OFS_AUX);

    // Mode, polarity and dead-band settings
    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ctrl_q  <= CTRL_RST;
            dband_q <= DBAND_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= i_wdata;
            end
            if (wr_dband) begin
                dband_q <= i_wdata;
            end
        end
    end

    // Shutdown configuration and auxiliary bits
    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            shdn_q <= SHDN_RST;
            aux_q  <= AUX_RST;
        end else begin
            if (wr_shdn) begin
                shdn_q <= i_wdata[6:0];
            end
            if (wr_aux) begin
                aux_q <= {i_wdata[AUX_DIRB_BIT], i_wdata[AUX_DIRA_BIT], i_wdata[AUX_SYNC_BIT]};
            end
        end
    end

    logic       half_en;
    logic       pwm_en;
    logic [1:0] pol;
    logic       auto_rst;
    logic [2:0] src;
    logic [1:0] sd_a;
    logic [1:0] sd_b;
    assign half_en  = ctrl_q[CTRL_HALF_BIT];
    assign pwm_en   = ctrl_q[CTRL_EN_BIT];
    assign pol      = {ctrl_q[CTRL_POLB_BIT], ctrl_q[CTRL_POLA_BIT]};
    assign auto_rst = dband_q[DB_ARST_BIT];
    assign src      = shdn_q[SD_SRC_LSB +: 3];
    assign sd_a     = shdn_q[SD_STA_LSB +: 2];
    assign sd_b     = shdn_q[SD_STB_LSB +: 2];

    // Read data, one cycle after the strobe
    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            unique case (i_addr)
                OFS_CTRL:  o_rdata <= ctrl_q;
                OFS_DBAND: o_rdata <= dband_q;
                OFS_SHDN:  o_rdata <= {flag_q, shdn_q};
                OFS_AUX:   o_rdata <= {ptf_q, 4'h0, aux_q};
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // Shutdown sources
    // ----------------------------------------------------------------
    logic int_meta_q;
    logic int_s_q;
    logic cmp_meta_q;
    logic cmp_s_q;
    logic cmp_lvl_q;

    // Source synchronisers and comparator timing
    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            int_meta_q <= 1'b1;
            int_s_q    <= 1'b1;
            cmp_meta_q <= 1'b0;
            cmp_s_q    <= 1'b0;
            cmp_lvl_q  <= 1'b0;
        end else begin
            int_meta_q <= i_int_pin;
            int_s_q    <= int_meta_q;
            cmp_meta_q <= i_cmp_out;
            cmp_s_q    <= cmp_meta_q;
            if (!aux_q[AUX_SYNC_BIT] || i_tmr1_tick) begin
                cmp_lvl_q <= cmp_s_q;
            end
        end
    end

    // Clocked condition from the selected sources
    assign cond_s = (src[SRC_CMP_BIT] && cmp_lvl_q)
                 || (src[SRC_INT_BIT] && !int_s_q);

    // Flag: events win over any clear
    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            flag_q <= 1'b0;
        end else if (cond_s) begin
            flag_q <= 1'b1;
        end else if (wr_shdn && i_wdata[SD_FLAG_BIT]) begin
            flag_q <= 1'b1;
        end else if (wr_shdn) begin
            flag_q <= 1'b0;
        end else if (auto_rst) begin
            flag_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Instruction-cycle enable
    // ----------------------------------------------------------------
    logic [1:0] div_q;
    logic       tcy_q;

    // One pulse every instruction cycle
    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            div_q <= 2'h0;
            tcy_q <= 1'b0;
        end else begin
            div_q <= div_q + 2'h1;
            tcy_q <= (div_q == 2'(TCY_DIV - 1));
        end
    end

    // ----------------------------------------------------------------
    // Sequencing and waveform
    // ----------------------------------------------------------------
    logic pwm_raw_q;

    // Start and restart only on period boundaries
    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            st_q <= HBP_ST_IDLE;
        end else begin
            unique case (st_q)
                HBP_ST_IDLE: begin
                    if (flag_q) begin
                        st_q <= HBP_ST_SHUT;
                    end else if (pwm_en && i_period_match) begin
                        st_q <= HBP_ST_RUN;
                    end
                end
                HBP_ST_RUN: begin
                    if (flag_q) begin
                        st_q <= HBP_ST_SHUT;
                    end else if (!pwm_en) begin
                        st_q <= HBP_ST_IDLE;
                    end
                end
                HBP_ST_SHUT: begin
                    if (!flag_q) begin
                        st_q <= HBP_ST_RESUME;
                    end
                end
                HBP_ST_RESUME: begin
                    if (flag_q) begin
                        st_q <= HBP_ST_SHUT;
                    end else if (i_period_match) begin
                        st_q <= HBP_ST_RUN;
                    end
                end
            endcase
        end
    end

    // Raw PWM from period and duty matches
    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pwm_raw_q <= 1'b0;
        end else if (st_q != HBP_ST_RUN
                     && !(i_period_match && pwm_en && !flag_q && st_q != HBP_ST_SHUT)) begin
            pwm_raw_q <= 1'b0;
        end else if (i_period_match) begin
            pwm_raw_q <= !i_duty_zero;
        end else if (i_duty_match) begin
            pwm_raw_q <= 1'b0;
        end
    end

    // Period timer flag; set wins over clear
    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ptf_q <= 1'b0;
        end else if (i_period_match) begin
            ptf_q <= 1'b1;
        end else if (wr_aux && !i_wdata[AUX_PTF_BIT]) begin
            ptf_q <= 1'b0;
        end
    end

    // Scheduled levels and dead band per output
    logic [1:0]          sched;
    logic [1:0]          db_act;
    logic [DB_WIDTH-1:0] db_cnt;
    assign sched[0] = pwm_raw_q;
    assign sched[1] = (st_q == HBP_ST_RUN) && (half_en ? !pwm_raw_q : pwm_raw_q);
    assign db_cnt   = half_en ? dband_q[DB_WIDTH-1:0] : '0;

    for (genvar g = 0; g < 2; g++) begin : g_db
        hbp_dead_band #(
            .DB_W     (DB_WIDTH)
        ) u_db (
            .i_clk    (i_clk),
            .i_rst_n  (rst_n_q),
            .i_tcy    (tcy_q),
            .i_sched  (sched[g]),
            .i_count  (db_cnt),
            .o_active (db_act[g])
        );
    end

    // ----------------------------------------------------------------
    // Pin stage
    // ----------------------------------------------------------------
    logic out_a_q;
    logic out_b_q;

    // Polarity after dead band
    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            out_a_q <= 1'b0;
            out_b_q <= 1'b0;
        end else begin
            out_a_q <= db_act[0] ^ pol[0];
            out_b_q <= db_act[1] ^ pol[1];
        end
    end
    // Period flag leaves straight from its register
    assign o_period_timer_flag = ptf_q;

    // Override from the flag, plus unclocked terms straight from the pins
    logic sd_async;
    assign sd_async = flag_q
                   || (src[SRC_INT_BIT] && !i_int_pin)
                   || (src[SRC_CMP_BIT] && !aux_q[AUX_SYNC_BIT] && i_cmp_out);

    // Shutdown state overrides polarity and delay
    assign o_pwm_out_a      = sd_async ? sd_a[0] : out_a_q;
    assign o_pwm_out_a_oe_n = sd_async ? (sd_a[1] || aux_q[AUX_DIRA_BIT]) : aux_q[AUX_DIRA_BIT];
    assign o_pwm_out_b      = sd_async ? sd_b[0] : out_b_q;
    assign o_pwm_out_b_oe_n = sd_async ? (sd_b[1] || aux_q[AUX_DIRB_BIT]) : aux_q[AUX_DIRB_BIT];

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!rst_n_q);

    property p_flag_set;
        cond_s |=> flag_q;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("condition did not set flag");

    property p_wr_ignored;
        cond_s && wr_shdn && !i_wdata[SD_FLAG_BIT] |=> flag_q;
    endproperty
    a_wr_ignored: assert property (p_wr_ignored) else $error("clear accepted in shutdown");

    property p_fw_event;
        wr_shdn && i_wdata[SD_FLAG_BIT] |=> flag_q;
    endproperty
    a_fw_event: assert property (p_fw_event) else $error("firmware event lost");

    property p_auto;
        flag_q && !cond_s && auto_rst && !wr_shdn |=> !flag_q;
    endproperty
    a_auto: assert property (p_auto) else $error("auto-restart did not clear");

    property p_force_a;
        flag_q && !sd_a[1] |-> o_pwm_out_a == sd_a[0];
    endproperty
    a_force_a: assert property (p_force_a) else $error("A not forced");

    property p_force_b;
        flag_q && sd_b[1] |-> o_pwm_out_b_oe_n;
    endproperty
    a_force_b: assert property (p_force_b) else $error("B not tri-stated");

    property p_resume;
        st_q == HBP_ST_RESUME && !i_period_match |=> !pwm_raw_q;
    endproperty
    a_resume: assert property (p_resume) else $error("resumed mid-period");

    property p_ptf;
        i_period_match |=> o_period_timer_flag;
    endproperty
    a_ptf: assert property (p_ptf) else $error("period flag missing");

    property p_pol;
        !sd_async |-> o_pwm_out_a == ($past(db_act[0]) ^ $past(pol[0]));
    endproperty
    a_pol: assert property (p_pol) else $error("A polarity wrong");

    property p_tcy;
        tcy_q |=> !tcy_q [*3] ##1 tcy_q;
    endproperty
    a_tcy: assert property (p_tcy) else $error("instruction cycle not four clocks");

    property p_hiz;
        $rose(rst_n_q) |-> o_pwm_out_a_oe_n && o_pwm_out_b_oe_n;
    endproperty
    a_hiz: assert property (p_hiz) else $error("pins driven after reset");

    c_shut:    cover property (st_q == HBP_ST_RUN ##1 st_q == HBP_ST_SHUT);
    c_restart: cover property (st_q == HBP_ST_RESUME ##1 st_q == HBP_ST_RUN);
    c_auto:    cover property (auto_rst && $fell(flag_q));
    c_delay:   cover property (half_en && $rose(db_act[1]));
endmodule // hbp_top

// ### hbp_far_side.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Far side: time base, shutdown sources and pulled-down load pins
// ----------------------------------------------------------------
module hbp_far_side #(
    parameter int PER  = 40,
    parameter int DUTY = 20
) (
    input  wire logic i_clk,
    input  wire logic i_int_low,
    input  wire logic i_cmp_high,
    input  wire logic i_pin_a,
    input  wire logic i_pin_a_oe_n,
    input  wire logic i_pin_b,
    input  wire logic i_pin_b_oe_n,
    output logic      o_period_match,
    output logic      o_duty_match,
    output logic      o_tmr1_tick,
    output logic      o_int_pin,
    output logic      o_cmp_out,
    output logic      o_load_a,
    output logic      o_load_b
);
    logic [7:0] cnt_q = 8'h00;

    // Free-running period counter
    always @(posedge i_clk) begin
        cnt_q <= (cnt_q == 8'(PER - 1)) ? 8'h00 : cnt_q + 8'h01;
    end

    // Time base pulses
    assign o_period_match = (cnt_q == 8'(PER - 1));
    assign o_duty_match   = (cnt_q == 8'(DUTY - 1));
    assign o_tmr1_tick    = (cnt_q[1:0] == 2'b11);

    // Shutdown sources: pin low, comparator high
    assign o_int_pin = ~i_int_low;
    assign o_cmp_out = i_cmp_high;

    // Pull-downs hold the switches off when pins float
    assign o_load_a = i_pin_a_oe_n ? 1'b0 : i_pin_a;
    assign o_load_b = i_pin_b_oe_n ? 1'b0 : i_pin_b;
endmodule // hbp_far_side

// ### hbp_top_bench.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Bench for the half-bridge output stage
// ----------------------------------------------------------------
module hbp_top_bench;
    import hbp_pkg::*;
    logic              i_clk = 1'b0;
    logic              i_rstn = 1'b0;
    logic [ADDR_W-1:0] i_addr = '0;
    logic [DATA_W-1:0] i_wdata = '0;
    logic              i_wr = 1'b0;
    logic              i_rd = 1'b0;
    logic [DATA_W-1:0] o_rdata;
    logic              pm, dm, tick, int_pin, cmp, pa, pa_oe_n, pb, pb_oe_n, la, lb, ptf;
    logic              int_low = 1'b0;
    logic              cmp_high = 1'b0;
    logic              acc;
    logic [1:0]        ca, cb;
    int                n_errors = 0;
    int                n_tests = 0;

    // Clock
    always #2 i_clk = ~i_clk;

    hbp_top uut (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_period_match(pm),
        .i_duty_match(dm), .i_duty_zero(1'b0), .i_int_pin(int_pin), .i_cmp_out(cmp),
        .i_tmr1_tick(tick), .o_pwm_out_a(pa), .o_pwm_out_a_oe_n(pa_oe_n),
        .o_pwm_out_b(pb), .o_pwm_out_b_oe_n(pb_oe_n), .o_period_timer_flag(ptf));

    hbp_far_side far (.i_clk(i_clk), .i_int_low(int_low), .i_cmp_high(cmp_high),
        .i_pin_a(pa), .i_pin_a_oe_n(pa_oe_n), .i_pin_b(pb), .i_pin_b_oe_n(pb_oe_n),
        .o_period_match(pm), .o_duty_match(dm), .o_tmr1_tick(tick), .o_int_pin(int_pin),
        .o_cmp_out(cmp), .o_load_a(la), .o_load_b(lb));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_clk);
        i_wr    <= 1'b0;
    endtask

    task automatic rchk(input logic [1:0] a, input logic [7:0] e);
        @(posedge i_clk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clk);
        i_rd   <= 1'b0;
        #1 chk(o_rdata, e);
    endtask

    // Pins as {oe_n a, load a, oe_n b, load b}
    task automatic pins(input logic [3:0] e);
        chk({4'h0, pa_oe_n, la, pb_oe_n, lb}, {4'h0, e});
    endtask

    // Sample pins a fixed number of cycles into a period
    task automatic at_off(input int off, input logic [3:0] e);
        @(posedge i_clk iff pm);
        cyc(off);
        #1 pins(e);
    endtask

    // Drivers off, reprogram, two full periods, drivers on
    task automatic setup(input logic [7:0] ctrl, input logic [7:0] db);
        wr(OFS_AUX, 8'h06);
        wr(OFS_CTRL, ctrl);
        wr(OFS_DBAND, db);
        cyc(90);
        rchk(OFS_AUX, 8'h86);
        wr(OFS_AUX, 8'h78);
        rchk(OFS_AUX, 8'h00);
    endtask

    task automatic wrap_up;
        $display("errors=%0d checks=%0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Watchdog
    initial begin
        cyc(20000);
        n_errors++;
        wrap_up();
    end

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        cyc(16);
        i_rstn <= 1'b1;
        cyc(3);
        rchk(OFS_CTRL, 8'h00);
        rchk(OFS_DBAND, 8'h00);
        rchk(OFS_SHDN, 8'h00);
        rchk(OFS_AUX, 8'h06);
        pins(4'b1010);
        // Complement and dead band
        setup(8'h88, 8'h00);
        at_off(10, 4'b0100);
        at_off(33, 4'b0001);
        wr(OFS_DBAND, 8'h02);
        at_off(7, 4'b0000);
        at_off(18, 4'b0100);
        at_off(27, 4'b0000);
        at_off(38, 4'b0001);
        wr(OFS_DBAND, 8'h1e);
        @(posedge i_clk iff pm);
        acc = 1'b0;
        repeat (40) begin
            @(posedge i_clk);
            acc = acc | la | lb;
        end
        chk({7'h0, acc}, 8'h00);
        // Polarity
        setup(8'h8b, 8'h00);
        at_off(10, 4'b0001);
        at_off(33, 4'b0100);
        // Single mode: B follows A, no dead band
        setup(8'h08, 8'h05);
        at_off(10, 4'b0101);
        at_off(33, 4'b0000);
        setup(8'h88, 8'h00);
        // Firmware event and shutdown states
        for (int i = 0; i < 3; i++) begin
            ca = (i == 2) ? 2'b10 : 2'(i);
            cb = 2'(2 - i);
            wr(OFS_SHDN, {1'b1, 3'b000, ca, cb});
            cyc(2);
            #1 pins({ca[1], ~ca[1] & ca[0], cb[1], ~cb[1] & cb[0]});
            rchk(OFS_SHDN, {1'b1, 3'b000, ca, cb});
            wr(OFS_SHDN, 8'h00);
        end
        // Every source code against both hardware sources
        for (int s = 0; s < 8; s++) begin
            for (int k = 0; k < 2; k++) begin
                wr(OFS_SHDN, {1'b0, 3'(s), 4'b0100});
                int_low  <= (k == 0);
                cmp_high <= (k == 1);
                cyc(6);
                rchk(OFS_SHDN, {(k == 1) ? s[0] : s[2], 3'(s), 4'b0100});
                int_low  <= 1'b0;
                cmp_high <= 1'b0;
                cyc(6);
                wr(OFS_SHDN, {1'b0, 3'(s), 4'b0100});
            end
        end
        // Async forcing, level hold, refused clear, restart point
        wr(OFS_SHDN, 8'h45);
        @(posedge i_clk iff pm);
        cyc(30);
        int_low <= 1'b1;
        #1 pins(4'b0101);
        cyc(6);
        wr(OFS_SHDN, 8'h45);
        rchk(OFS_SHDN, 8'hc5);
        #1 pins(4'b0101);
        int_low <= 1'b0;
        cyc(6);
        wr(OFS_SHDN, 8'h45);
        acc = 1'b0;
        do begin
            @(posedge i_clk);
            acc = acc | la | lb;
        end while (!pm);
        chk({7'h0, acc}, 8'h00);
        cyc(10);
        #1 pins(4'b0100);
        // Auto-restart
        wr(OFS_DBAND, 8'h80);
        int_low <= 1'b1;
        cyc(6);
        rchk(OFS_SHDN, 8'hc5);
        int_low <= 1'b0;
        cyc(8);
        rchk(OFS_SHDN, 8'h45);
        // Comparator sync: no unclocked forcing, flag still follows
        wr(OFS_AUX, 8'h01);
        wr(OFS_SHDN, 8'h1a);
        cmp_high <= 1'b1;
        #1 chk({6'h0, pa_oe_n, pb_oe_n}, 8'h00);
        cyc(8);
        rchk(OFS_SHDN, 8'h9a);
        cmp_high <= 1'b0;
        cyc(8);
        rchk(OFS_SHDN, 8'h1a);
        wrap_up();
    end
endmodule // hbp_top_bench
